// ===== logic/usbtc_map.svh
// Constant map for the USB line termination control block.
// Included by the design modules and the testbench; definitions only.
`ifndef USBTC_MAP_SVH
`define USBTC_MAP_SVH

// Register byte offsets
`define USBTC_OFS_LINE_CTRL   8'h00
`define USBTC_OFS_OTG_CTRL    8'h04
`define USBTC_OFS_ANALOG_CTRL 8'h08
`define USBTC_OFS_TERM_STATUS 8'h0c

// Line control field positions
`define USBTC_XCVR_LSB 0
`define USBTC_TERM_BIT 2
`define USBTC_OPM_LSB 3
// Otg control field positions
`define USBTC_DPPD_BIT 0
`define USBTC_DMPD_BIT 1
`define USBTC_CHG_BIT 2
`define USBTC_DCHG_BIT 3
`define USBTC_IDPU_BIT 4
`define USBTC_IDGND_BIT 5
// Analog control field positions
`define USBTC_BOOST_LSB 0
`define USBTC_REG_LSB 3
`define USBTC_UART_BIT 5

// Reset values: full-speed select, normal mode, pull-downs requested
`define USBTC_RST_LINE_CTRL 5'h01
`define USBTC_RST_OTG_CTRL 6'h03
`define USBTC_RST_ANALOG_CTRL 6'h00

`endif

// ===== logic/usbtc_pkg.sv
// Types shared by the termination control block.
// Assumes nothing beyond the constant map.
package usbtc_pkg;
    typedef enum logic [1:0] {
        USBTC_OPM_NORMAL = 2'h0,
        USBTC_OPM_NODRIVE = 2'h1,
        USBTC_OPM_NO_NRZI = 2'h2,
        USBTC_OPM_RSVD = 2'h3
    } usbtc_operating_mode_t;

    typedef struct packed {
        logic pu_dp;
        logic pu_dm;
        logic pd_dp;
        logic pd_dm;
        logic hs_term;
    } usbtc_term_t;

    typedef enum logic [2:0] {
        USBTC_ST_IDLE = 3'b001,
        USBTC_ST_ACK = 3'b010,
        USBTC_ST_DONE = 3'b100
    } usbtc_bus_st_t;
endpackage

// ===== logic/usbtc_term_decode.sv
// Termination decode: register bits to five resistor enables.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "usbtc_map.svh"
module usbtc_term_decode
    import usbtc_pkg::*;
(
    // Programmed line settings
    input wire logic [1:0] transceiver_speed_select_i,
    input wire logic termination_select_i,
    input wire logic [1:0] operating_mode_i,
    input wire logic plus_line_pulldown_request_i,
    input wire logic minus_line_pulldown_request_i,
    // Decoded enables
    output usbtc_term_t term_o,
    output logic defined_o
);
    logic pd_both;
    assign pd_both = plus_line_pulldown_request_i & minus_line_pulldown_request_i;

    always_comb begin
        term_o = '0;
        defined_o = 1'b0;
        if (operating_mode_i == USBTC_OPM_NODRIVE) begin
            defined_o = 1'b1;
        end else if (pd_both) begin
            if (transceiver_speed_select_i == 2'h1 && !termination_select_i
                    && operating_mode_i == USBTC_OPM_NORMAL) begin
                term_o.pd_dp = 1'b1;
                term_o.pd_dm = 1'b1;
                defined_o = 1'b1;
            end else if (transceiver_speed_select_i == 2'h0 && !termination_select_i
                    && (operating_mode_i == USBTC_OPM_NORMAL
                    || operating_mode_i == USBTC_OPM_NO_NRZI)) begin
                term_o.pd_dp = 1'b1;
                term_o.pd_dm = 1'b1;
                term_o.hs_term = 1'b1;
                defined_o = 1'b1;
            end else if (termination_select_i
                    && ((transceiver_speed_select_i[0] && operating_mode_i == USBTC_OPM_NORMAL)
                    || (transceiver_speed_select_i == 2'h1
                    && operating_mode_i == USBTC_OPM_NO_NRZI)
                    || (transceiver_speed_select_i == 2'h2
                    && operating_mode_i != USBTC_OPM_NODRIVE
                    && operating_mode_i != USBTC_OPM_RSVD))) begin
                term_o.pd_dp = 1'b1;
                term_o.pd_dm = 1'b1;
                defined_o = 1'b1;
            end
        end
        // Anything else falls through to all-off
    end
endmodule // usbtc_term_decode

// ===== logic/usbtc_analog_ctrl.sv
// Analog control decode: boost level, regulator level, bus power and id pull controls.
// Inputs come from registers in the top module.
`timescale 1ns/1ps
`include "usbtc_map.svh"
module usbtc_analog_ctrl (
    // Control bits
    input wire logic [2:0] boost_i,
    input wire logic uart_mode_i,
    input wire logic [1:0] regulator_level_select_i,
    input wire logic charge_i,
    input wire logic discharge_i,
    input wire logic id_pullup_i,
    // Analog enables
    output logic [7:0] hs_amp_step_o,
    output logic [1:0] regulator_trim_o,
    output logic bus_power_charge_enable_o,
    output logic bus_power_discharge_enable_o,
    output logic id_line_strong_pullup_o,
    output logic id_line_weak_pullup_o
);
    // Thermometer code of boost steps for the amplitude DAC
    function automatic logic [7:0] therm(input logic [2:0] v);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 0; i < 8; i++) begin
            t[i] = (3'(i) < v);
        end
        return t;
    endfunction

    assign hs_amp_step_o = therm(boost_i);
    // 0 = nominal 3.3 V; 1/2/3 = 3.0/2.75/2.5 V, only in serial mode
    assign regulator_trim_o = uart_mode_i ? regulator_level_select_i : 2'h0;
    assign bus_power_charge_enable_o = charge_i;
    assign bus_power_discharge_enable_o = discharge_i;
    assign id_line_strong_pullup_o = id_pullup_i;
    assign id_line_weak_pullup_o = 1'b1;
endmodule // usbtc_analog_ctrl

// ===== logic/usbtc_top.sv
// Top of the USB line termination control block with Wishbone register slave.
// Assumes a classic Wishbone master on clk_i and a synchronous active-high reset.
`timescale 1ns/1ps
`include "usbtc_map.svh"
module usbtc_top
    import usbtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Line terminations
    output logic plus_line_pullup_enable_o,
    output logic minus_line_pullup_enable_o,
    output logic plus_line_pulldown_enable_o,
    output logic minus_line_pulldown_enable_o,
    output logic highspeed_termination_enable_o,
    // Analog controls
    output logic [7:0] hs_amp_step_o,
    output logic [1:0] regulator_trim_o,
    output logic bus_power_charge_enable_o,
    output logic bus_power_discharge_enable_o,
    output logic id_line_strong_pullup_o,
    output logic id_line_weak_pullup_o,
    output logic id_line_ground_drive_o
);
    logic [4:0] line_ctrl_r;
    logic [5:0] otg_ctrl_r;
    logic [5:0] analog_ctrl_r;
    usbtc_term_t term_nxt;
    usbtc_term_t term_r;
    logic defined_nxt;
    logic defined_r;
    logic [7:0] amp_nxt;
    logic [1:0] trim_nxt;
    logic chg_nxt;
    logic dchg_nxt;
    logic idpu_nxt;
    logic idweak_nxt;
    logic [7:0] amp_r;
    logic [1:0] trim_r;
    logic chg_r;
    logic dchg_r;
    logic idpu_r;
    logic idweak_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic req;
    logic wr_go;

    // Single-cycle answer; ack drops after one cycle even if stb holds
    assign req = cyc_i & stb_i & ~ack_r;
    assign wr_go = req & we_i & sel_i[0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // Register writes; only the low byte lane holds fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_ctrl_r <= `USBTC_RST_LINE_CTRL;
            otg_ctrl_r <= `USBTC_RST_OTG_CTRL;
            analog_ctrl_r <= `USBTC_RST_ANALOG_CTRL;
        end else if (wr_go) begin
            if (hit(adr_i, `USBTC_OFS_LINE_CTRL)) begin
                line_ctrl_r <= dat_i[4:0];
            end
            if (hit(adr_i, `USBTC_OFS_OTG_CTRL)) begin
                otg_ctrl_r <= dat_i[5:0];
            end
            if (hit(adr_i, `USBTC_OFS_ANALOG_CTRL)) begin
                analog_ctrl_r <= dat_i[5:0];
            end
        end
    end

    // Read data, unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !we_i) begin
            case (adr_i)
                `USBTC_OFS_LINE_CTRL: begin
                    dat_r <= {27'h0, line_ctrl_r};
                end
                `USBTC_OFS_OTG_CTRL: begin
                    dat_r <= {26'h0, otg_ctrl_r};
                end
                `USBTC_OFS_ANALOG_CTRL: begin
                    dat_r <= {26'h0, analog_ctrl_r};
                end
                `USBTC_OFS_TERM_STATUS: begin
                    dat_r <= {26'h0, defined_r, term_r};
                end
                default: begin
                    dat_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    usbtc_term_decode u_term (
        .transceiver_speed_select_i(line_ctrl_r[`USBTC_XCVR_LSB +: 2]),
        .termination_select_i(line_ctrl_r[`USBTC_TERM_BIT]),
        .operating_mode_i(line_ctrl_r[`USBTC_OPM_LSB +: 2]),
        .plus_line_pulldown_request_i(otg_ctrl_r[`USBTC_DPPD_BIT]),
        .minus_line_pulldown_request_i(otg_ctrl_r[`USBTC_DMPD_BIT]),
        .term_o(term_nxt),
        .defined_o(defined_nxt)
    );

    usbtc_analog_ctrl u_analog (
        .boost_i(analog_ctrl_r[`USBTC_BOOST_LSB +: 3]),
        .uart_mode_i(analog_ctrl_r[`USBTC_UART_BIT]),
        .regulator_level_select_i(analog_ctrl_r[`USBTC_REG_LSB +: 2]),
        .charge_i(otg_ctrl_r[`USBTC_CHG_BIT]),
        .discharge_i(otg_ctrl_r[`USBTC_DCHG_BIT]),
        .id_pullup_i(otg_ctrl_r[`USBTC_IDPU_BIT]),
        .hs_amp_step_o(amp_nxt),
        .regulator_trim_o(trim_nxt),
        .bus_power_charge_enable_o(chg_nxt),
        .bus_power_discharge_enable_o(dchg_nxt),
        .id_line_strong_pullup_o(idpu_nxt),
        .id_line_weak_pullup_o(idweak_nxt)
    );

    // Registered termination enables, glitch free to the analog switches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_r <= '0;
            defined_r <= 1'b0;
        end else begin
            term_r <= term_nxt;
            defined_r <= defined_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_r <= 8'h00;
            trim_r <= 2'h0;
            chg_r <= 1'b0;
            dchg_r <= 1'b0;
            idpu_r <= 1'b0;
            idweak_r <= 1'b1;
        end else begin
            amp_r <= amp_nxt;
            trim_r <= trim_nxt;
            chg_r <= chg_nxt;
            dchg_r <= dchg_nxt;
            idpu_r <= idpu_nxt;
            idweak_r <= idweak_nxt;
        end
    end

    assign plus_line_pullup_enable_o = term_r.pu_dp;
    assign minus_line_pullup_enable_o = term_r.pu_dm;
    assign plus_line_pulldown_enable_o = term_r.pd_dp;
    assign minus_line_pulldown_enable_o = term_r.pd_dm;
    assign highspeed_termination_enable_o = term_r.hs_term;
    assign hs_amp_step_o = amp_r;
    assign regulator_trim_o = trim_r;
    assign bus_power_charge_enable_o = chg_r;
    assign bus_power_discharge_enable_o = dchg_r;
    assign id_line_strong_pullup_o = idpu_r;
    assign id_line_weak_pullup_o = idweak_r;
    assign id_line_ground_drive_o = otg_ctrl_r[`USBTC_IDGND_BIT];

    // Assertions
    logic [1:0] xs;
    logic ts;
    logic [1:0] om;
    logic pdb;
    assign xs = line_ctrl_r[`USBTC_XCVR_LSB +: 2];
    assign ts = line_ctrl_r[`USBTC_TERM_BIT];
    assign om = line_ctrl_r[`USBTC_OPM_LSB +: 2];
    assign pdb = otg_ctrl_r[`USBTC_DPPD_BIT] & otg_ctrl_r[`USBTC_DMPD_BIT];

    sequence s_wr_line;
        wr_go && adr_i == `USBTC_OFS_LINE_CTRL;
    endsequence

    // Host full/low speed rows: speed X1 in normal mode, 01 no-NRZI, 10 normal or no-NRZI
    sequence s_host_row;
        ts && pdb && ((xs[0] && om == 2'h0) || (xs == 2'h1 && om == 2'h2)
            || (xs == 2'h2 && (om == 2'h0 || om == 2'h2)));
    endsequence

    sequence s_rd_req;
        req && !we_i;
    endsequence

    sequence s_wr_otg;
        wr_go && adr_i == `USBTC_OFS_OTG_CTRL;
    endsequence

    sequence s_wr_analog;
        wr_go && adr_i == `USBTC_OFS_ANALOG_CTRL;
    endsequence

    AST_NODRIVE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        om == 2'h1 |=> term_r == '0)
        else $error("mode 01 left an enable on");
    AST_POWERUP: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && xs == 2'h1 && !ts && om == 2'h0 && pdb) |=> term_r == 5'b00110)
        else $error("power-up setting wrong");
    AST_HS_TERM: assert property (@(posedge clk_i) disable iff (rst_i)
        (xs == 2'h0 && !ts && (om == 2'h0 || om == 2'h2) && pdb) |=> term_r == 5'b00111)
        else $error("high-speed host setting wrong");
    AST_HOST_FS: assert property (@(posedge clk_i) disable iff (rst_i)
        s_host_row |=> term_r == 5'b00110)
        else $error("host fs/ls setting wrong");
    AST_FALLBACK: assert property (@(posedge clk_i) disable iff (rst_i)
        !defined_nxt |=> term_r == '0 && !defined_r)
        else $error("fallback not all off");
    AST_NO_PULLUP: assert property (@(posedge clk_i) disable iff (rst_i)
        !(plus_line_pullup_enable_o || minus_line_pullup_enable_o))
        else $error("pull-up on in host-only decode");
    AST_LINE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_line ##1 1'b1 |-> line_ctrl_r == $past(dat_i[4:0]))
        else $error("line control write lost");
    AST_CHARGE: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> bus_power_charge_enable_o == $past(otg_ctrl_r[`USBTC_CHG_BIT]))
        else $error("charge enable mismatch");
    AST_DISCHARGE: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> bus_power_discharge_enable_o == $past(otg_ctrl_r[`USBTC_DCHG_BIT]))
        else $error("discharge enable mismatch");
    AST_ID_PULL: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> id_line_weak_pullup_o
            && id_line_strong_pullup_o == $past(otg_ctrl_r[`USBTC_IDPU_BIT]))
        else $error("id pull-up mismatch");
    AST_REG_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
        analog_ctrl_r[`USBTC_UART_BIT] ##1 1'b1 |->
            regulator_trim_o == $past(analog_ctrl_r[`USBTC_REG_LSB +: 2]))
        else $error("regulator level mismatch");
    AST_BOOST: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> $countones(hs_amp_step_o) == $past(analog_ctrl_r[`USBTC_BOOST_LSB +: 3]))
        else $error("boost step mismatch");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");

    // Bus handshake: every taken request is answered in the next cycle, nothing else is
    AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o)
        else $error("request not acknowledged");
    AST_ACK_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !req |=> !ack_o)
        else $error("ack without request");

    // Read data stands with ack and carries the register sampled when the request was taken
    AST_RD_LINE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rd_req ##0 adr_i == `USBTC_OFS_LINE_CTRL |=> dat_o == {27'h0, $past(line_ctrl_r)})
        else $error("line control read wrong");
    AST_RD_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rd_req ##0 adr_i == `USBTC_OFS_TERM_STATUS |=>
            dat_o == {26'h0, $past(defined_r), $past(term_r)})
        else $error("status read wrong");

    // Writes land in the cycle after they are taken; a missing low byte lane changes nothing
    AST_OTG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_otg |=> otg_ctrl_r == $past(dat_i[5:0]))
        else $error("otg control write lost");
    AST_ANALOG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wr_analog |=> analog_ctrl_r == $past(dat_i[5:0]))
        else $error("analog control write lost");
    AST_LANE_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
        req && we_i && !sel_i[0] |=> $stable(line_ctrl_r) && $stable(otg_ctrl_r)
            && $stable(analog_ctrl_r))
        else $error("write without byte lane changed a register");

    // Enables follow the decode one cycle later, so the switches never see decode glitches
    AST_TERM_LAG: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |=> term_r == $past(term_nxt))
        else $error("termination enables not registered from decode");
    AST_HS_NEEDS_PD: assert property (@(posedge clk_i) disable iff (rst_i)
        highspeed_termination_enable_o |-> plus_line_pulldown_enable_o
            && minus_line_pulldown_enable_o)
        else $error("high-speed termination without pull-downs");
    AST_PD_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
        plus_line_pulldown_enable_o == minus_line_pulldown_enable_o)
        else $error("pull-downs split in host decode");
    AST_REG_NOMINAL: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !analog_ctrl_r[`USBTC_UART_BIT] |=> regulator_trim_o == 2'h0)
        else $error("regulator trimmed outside serial mode");
endmodule // usbtc_top

// ===== test/usbtc_link_model.sv
// Link-side model: classic Wishbone master that programs the block registers.
// Assumes a slave on clk_i that answers each request with a one-cycle ack.
`timescale 1ns/1ps
module usbtc_link_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // Request held until ack is sampled, released at that same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] r, output bit ok);
        ok = 1'b0;
        r = 32'h0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_i);
            if (ack_i === 1'b1) begin
                ok = 1'b1;
                r = dat_i;
            end
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released data lines show no stale value
        dat_o <= ~d;
    endtask
endmodule // usbtc_link_model

// ===== test/usb_phy_termination_control_tb_top.sv
// Testbench: sweeps line, pull-down and analog settings through the link model.
// Assumes the constant map offsets and a one-cycle ack from the slave.
`timescale 1ns/1ps
`include "usbtc_map.svh"
module usb_phy_termination_control_tb_top;
    logic clk_i;
    logic rst_i;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    wire [4:0] term;
    logic [7:0] amp;
    logic [1:0] trim;
    logic chg, dchg, idpu, idw, idg;
    int errors = 0;
    int compares = 0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];

    usbtc_link_model link (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

    usbtc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .plus_line_pullup_enable_o(term[4]), .minus_line_pullup_enable_o(term[3]),
        .plus_line_pulldown_enable_o(term[2]), .minus_line_pulldown_enable_o(term[1]),
        .highspeed_termination_enable_o(term[0]), .hs_amp_step_o(amp),
        .regulator_trim_o(trim), .bus_power_charge_enable_o(chg),
        .bus_power_discharge_enable_o(dchg), .id_line_strong_pullup_o(idpu),
        .id_line_weak_pullup_o(idw), .id_line_ground_drive_o(idg));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        logic [31:0] r;
        bit ok;
        link.xfer(w, a, s, d, r, ok);
        if (!ok) begin
            errors++;
            end_sim();
        end
    endtask

    // Notes the expected read value; the monitor compares it when ack comes
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 4'hf, 32'h0);
    endtask

    // Expected {defined, pu_dp, pu_dm, pd_dp, pd_dm, hs} for host and general rows
    function automatic logic [5:0] decode(input logic [4:0] ln, input logic [1:0] pd);
        if (ln[4:3] == 2'h1) return 6'h20;
        if (pd != 2'h3) return 6'h00;
        if (!ln[2] && ln[1:0] == 2'h1 && ln[4:3] == 2'h0) return 6'h26;
        if (!ln[2] && ln[1:0] == 2'h0 && !ln[3]) return 6'h27;
        if (ln[2] && ((ln[0] && ln[4:3] == 2'h0) || (ln[1:0] == 2'h1 && ln[4:3] == 2'h2)
            || (ln[1:0] == 2'h2 && !ln[3]))) return 6'h26;
        return 6'h00;
    endfunction

    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk(rdat & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        end_sim();
    end

    initial begin
        logic [5:0] dec;
        logic [5:0] o;
        rst_i = 1'b1;
        void'($urandom(7158));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        chk({term, idw, amp, trim}, {5'h06, 1'b1, 8'h00, 2'h0});
        rd(`USBTC_OFS_LINE_CTRL, 32'h01, 32'hff);
        rd(`USBTC_OFS_OTG_CTRL, 32'h03, 32'hff);
        rd(`USBTC_OFS_ANALOG_CTRL, 32'h00, 32'hff);
        // Writes without byte 0 enable and to an unmapped place change nothing
        bus(1'b1, `USBTC_OFS_LINE_CTRL, 4'he, 32'h1f);
        bus(1'b1, 8'h10, 4'hf, 32'hff);
        rd(`USBTC_OFS_LINE_CTRL, 32'h01, 32'hff);
        rd(8'h10, 32'h0, 32'hffffffff);
        for (int i = 0; i < 128; i++) begin
            dec = decode(i[4:0], i[6:5]);
            bus(1'b1, `USBTC_OFS_OTG_CTRL, 4'h1, {30'h0, i[6:5]});
            bus(1'b1, `USBTC_OFS_LINE_CTRL, 4'h1, {27'h0, i[4:0]});
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk({27'h0, term}, {27'h0, dec[4:0]});
            rd(`USBTC_OFS_TERM_STATUS, {26'h0, dec}, 32'h3f);
            rd(`USBTC_OFS_LINE_CTRL, {27'h0, i[4:0]}, 32'h1f);
        end
        for (int i = 0; i < 64; i++) begin
            o = 6'($urandom());
            bus(1'b1, `USBTC_OFS_OTG_CTRL, 4'h1, {26'h0, o});
            bus(1'b1, `USBTC_OFS_ANALOG_CTRL, 4'h1, {26'h0, i[5:0]});
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk({24'h0, amp}, {24'h0, (8'h1 << i[2:0]) - 8'h1});
            chk({30'h0, trim}, {30'h0, i[5] ? i[4:3] : 2'h0});
            chk({28'h0, chg, dchg, idpu, idw}, {28'h0, o[2], o[3], o[4], 1'b1});
            chk({31'h0, idg}, {31'h0, o[5]});
            rd(`USBTC_OFS_ANALOG_CTRL, i, 32'h3f);
        end
        end_sim();
    end
endmodule // usb_phy_termination_control_tb_top
